// file: cpu_instruction_decode_timing.sv
// instruction decode and one- or two-cycle execution sequencer
`timescale 1ns/1ps
`include "decode_cfg.svh"

module cpu_instruction_decode_timing
	import decode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [`CFG_INSTR_WIDTH-1:0] instr_word,
	input wire logic test_true,
	input wire logic pc_changed,
	output logic fetch_strobe,
	output logic cycle_start,
	output logic [`CFG_PHASE_WIDTH-1:0] phase,
	output logic exec_active,
	output logic nop_cycle,
	output logic [`CFG_INSTR_WIDTH-1:0] exec_word,
	output instr_fields_s fields,
	output logic acc_write,
	output logic file_write
);

	////////////////////////////////////////////////////////////////////////////
	// phase counter and field splitter

	logic [`CFG_PHASE_WIDTH-1:0] q_phase;
	logic q_last;
	instr_fields_s split_fields;

	quarter_phase u_phase (
		.sys_clk(sys_clk),
		.reset(reset),
		.phase(q_phase),
		.cycle_last(q_last)
	);

	field_split u_split (
		.word(instr_word),
		.fields(split_fields)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer state

	seq_state_s st;
	seq_state_s next_st;
	logic take_phase;
	logic decide_phase;
	logic branch_now;

	always_comb begin
		take_phase = (q_phase == `CFG_PHASE_TAKE);
		decide_phase = (q_phase == `CFG_PHASE_DECIDE);
		// a test only counts for instructions that have one
		branch_now = st.fields.jumps || pc_changed ||
			(st.fields.conditional && test_true);
	end

	always_comb begin
		next_st = st;
		next_st.acc_write = 1'b0;
		next_st.file_write = 1'b0;
		next_st.fetch_strobe = 1'b0;
		next_st.cycle_start = 1'b0;
		// registered copy, so it trails the counter by one period
		next_st.phase = q_phase;
		if (q_phase == `CFG_PHASE_LAST) begin
			next_st.cycle_start = 1'b1;
		end
		case (st.mode)
			MODE_FILL: begin
				// after reset nothing is fetched yet, so run one empty cycle
				next_st.exec_active = 1'b0;
				next_st.nop_cycle = 1'b1;
				if (decide_phase) begin
					next_st.fetch_strobe = 1'b1;
				end
				if (q_last) begin
					next_st.mode = MODE_EXEC;
				end
			end
			MODE_EXEC: begin
				if (take_phase) begin
					next_st.word = instr_word;
					next_st.fields = split_fields;
					next_st.exec_active = 1'b1;
					next_st.nop_cycle = 1'b0;
					next_st.two_cycle = 1'b0;
				end
				if (decide_phase && st.exec_active) begin
					next_st.two_cycle = branch_now;
					next_st.acc_write = st.fields.writes_acc;
					next_st.file_write = st.fields.writes_file;
					next_st.fetch_strobe = 1'b1;
				end
				if (q_last) begin
					if (st.two_cycle) begin
						next_st.mode = MODE_NOP;
					end else begin
						next_st.mode = MODE_EXEC;
					end
				end
			end
			MODE_NOP: begin
				// prefetched word is left on the bus and never captured
				if (take_phase) begin
					next_st.exec_active = 1'b0;
					next_st.nop_cycle = 1'b1;
					next_st.two_cycle = 1'b0;
				end
				// refetch from the new program counter at the usual point
				if (decide_phase) begin
					next_st.fetch_strobe = 1'b1;
				end
				if (q_last) begin
					next_st.mode = MODE_EXEC;
				end
			end
			default: begin
				next_st.mode = MODE_FILL;
				next_st.exec_active = 1'b0;
				next_st.nop_cycle = 1'b1;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st <= '0;
			st.mode <= MODE_FILL;
			st.fields.instr_class <= CLASS_REGISTER;
			st.word <= `CFG_RESET_WORD;
			st.nop_cycle <= 1'b1;
			st.phase <= `CFG_RESET_PHASE;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register

	assign fetch_strobe = st.fetch_strobe;
	assign cycle_start = st.cycle_start;
	assign phase = st.phase;
	assign exec_active = st.exec_active;
	assign nop_cycle = st.nop_cycle;
	assign exec_word = st.word;
	assign fields = st.fields;
	assign acc_write = st.acc_write;
	assign file_write = st.file_write;

endmodule

// file: decode_cfg.svh
// constants for the instruction decode and timing block
//
// How it works
// - instruction is 14-bit opcode plus operands
// - three classes: register, bit, literal/control
// - result_target zero to accumulator, one to register
// - register_operand addresses registers 0x00 to 0x7F
// - position_in_register picks bit of 8-bit register
// - literal_constant is eight or eleven bits
// - ignored_position bits never change behaviour
// - one instruction cycle unless test or branch
// - true test or branch adds no-operation cycle
// - instruction cycle is four oscillator periods
// - register_operand names register holding targeted bit
`ifndef DECODE_CFG_SVH
`define DECODE_CFG_SVH

`define CFG_INSTR_WIDTH 14
`define CFG_CLASS_HI 13
`define CFG_CLASS_LO 12
`define CFG_SUBOP_HI 11
`define CFG_SUBOP_LO 8
`define CFG_REG_WIDTH 7
`define CFG_REG_HI 6
`define CFG_REG_LO 0
`define CFG_DEST_BIT 7
`define CFG_BITPOS_WIDTH 3
`define CFG_BITPOS_HI 9
`define CFG_BITPOS_LO 7
`define CFG_DATA_WIDTH 8
`define CFG_LIT_WIDTH 11
`define CFG_LIT8_HI 7
`define CFG_LIT11_HI 10
`define CFG_WIDE_BIT 11

// class field encodings
`define CFG_CLASS_BYTE 2'h0
`define CFG_CLASS_BIT 2'h1
`define CFG_CLASS_JUMP 2'h2
`define CFG_CLASS_LIT 2'h3
// byte sub-opcodes that skip on a true test
`define CFG_SUBOP_DEC_SKIP 4'hB
`define CFG_SUBOP_INC_SKIP 4'hF
// bit class: bits 11:10 of 2 and 3 are tests, 0 and 1 write
`define CFG_BITOP_TEST_BIT 11

// timing
`define CFG_OSC_PER_CYCLE 4
`define CFG_PHASE_WIDTH 2
`define CFG_PHASE_TAKE 2'h0
`define CFG_PHASE_DECIDE 2'h2
`define CFG_PHASE_LAST 2'h3

// reset values
`define CFG_RESET_WORD 14'h0000
`define CFG_RESET_PHASE 2'h0

`endif

// file: decode_pkg.sv
// types shared by the instruction decode and timing block
`include "decode_cfg.svh"

package decode_pkg;

	typedef enum logic [2:0] {
		CLASS_REGISTER = 3'h1,
		CLASS_BIT = 3'h2,
		CLASS_LITERAL = 3'h4
	} instr_class_e;

	typedef enum logic [2:0] {
		MODE_FILL = 3'h1,
		MODE_EXEC = 3'h2,
		MODE_NOP = 3'h4
	} seq_mode_e;

	typedef struct packed {
		instr_class_e instr_class;
		logic [`CFG_SUBOP_HI-`CFG_SUBOP_LO:0] sub_opcode;
		logic [`CFG_REG_WIDTH-1:0] reg_addr;
		logic result_to_file;
		logic [`CFG_BITPOS_WIDTH-1:0] bit_pos;
		logic [`CFG_DATA_WIDTH-1:0] bit_mask;
		logic [`CFG_LIT_WIDTH-1:0] literal;
		logic literal_wide;
		logic conditional;
		logic jumps;
		logic writes_acc;
		logic writes_file;
	} instr_fields_s;

	typedef struct packed {
		logic [`CFG_PHASE_WIDTH-1:0] phase;
	} phase_state_s;

	typedef struct packed {
		seq_mode_e mode;
		instr_fields_s fields;
		logic [`CFG_INSTR_WIDTH-1:0] word;
		logic two_cycle;
		logic exec_active;
		logic nop_cycle;
		logic acc_write;
		logic file_write;
		logic fetch_strobe;
		logic cycle_start;
		logic [`CFG_PHASE_WIDTH-1:0] phase;
	} seq_state_s;

endpackage

// file: quarter_phase.sv
// oscillator period counter that marks out one instruction cycle
`timescale 1ns/1ps
`include "decode_cfg.svh"

module quarter_phase
	import decode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	output logic [`CFG_PHASE_WIDTH-1:0] phase,
	output logic cycle_last
);

	phase_state_s st;
	phase_state_s next_st;

	always_comb begin
		next_st = st;
		// wraps after four periods, counter width fits the count exactly
		if (st.phase == `CFG_PHASE_LAST) begin
			next_st.phase = `CFG_RESET_PHASE;
		end else begin
			next_st.phase = st.phase + 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st <= '{phase: `CFG_RESET_PHASE};
		end else begin
			st <= next_st;
		end
	end

	assign phase = st.phase;
	assign cycle_last = (st.phase == `CFG_PHASE_LAST);

endmodule

// file: field_split.sv
// splits an instruction word into its class and operand fields
`timescale 1ns/1ps
`include "decode_cfg.svh"

module field_split
	import decode_pkg::*;
(
	input wire logic [`CFG_INSTR_WIDTH-1:0] word,
	output instr_fields_s fields
);

	logic [1:0] class_code;
	logic [`CFG_SUBOP_HI-`CFG_SUBOP_LO:0] subop;

	always_comb begin
		class_code = word[`CFG_CLASS_HI:`CFG_CLASS_LO];
		subop = word[`CFG_SUBOP_HI:`CFG_SUBOP_LO];
		fields = '0;
		fields.instr_class = CLASS_REGISTER;
		fields.sub_opcode = subop;
		fields.reg_addr = word[`CFG_REG_HI:`CFG_REG_LO];
		fields.result_to_file = word[`CFG_DEST_BIT];
		fields.bit_pos = word[`CFG_BITPOS_HI:`CFG_BITPOS_LO];
		fields.bit_mask = 8'h01 << word[`CFG_BITPOS_HI:`CFG_BITPOS_LO];
		case (class_code)
			`CFG_CLASS_BYTE: begin
				fields.instr_class = CLASS_REGISTER;
				fields.conditional = (subop == `CFG_SUBOP_DEC_SKIP) ||
					(subop == `CFG_SUBOP_INC_SKIP);
				fields.writes_acc = !word[`CFG_DEST_BIT];
				fields.writes_file = word[`CFG_DEST_BIT];
			end
			`CFG_CLASS_BIT: begin
				fields.instr_class = CLASS_BIT;
				fields.result_to_file = 1'b1;
				// bit position sits where result_target would be
				fields.conditional = word[`CFG_BITOP_TEST_BIT];
				fields.writes_file = !word[`CFG_BITOP_TEST_BIT];
			end
			`CFG_CLASS_JUMP: begin
				fields.instr_class = CLASS_LITERAL;
				fields.literal_wide = 1'b1;
				fields.literal = word[`CFG_LIT11_HI:0];
				fields.jumps = 1'b1;
				fields.result_to_file = 1'b0;
			end
			default: begin
				fields.instr_class = CLASS_LITERAL;
				// upper bits of an eight-bit literal are don't care
				fields.literal = {3'h0, word[`CFG_LIT8_HI:0]};
				fields.writes_acc = 1'b1;
				fields.result_to_file = 1'b0;
			end
		endcase
		if (fields.instr_class == CLASS_LITERAL) begin
			fields.bit_mask = 8'h00;
			fields.bit_pos = 3'h0;
			fields.reg_addr = 7'h00;
		end
	end

endmodule

// file: decode_props.sv
// port assertions for the instruction decode and timing block
`timescale 1ns/1ps
`include "decode_cfg.svh"
module decode_props
	import decode_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic fetch_strobe,
	input wire logic cycle_start,
	input wire logic exec_active,
	input wire logic nop_cycle,
	input wire logic [`CFG_INSTR_WIDTH-1:0] exec_word,
	input instr_fields_s fields,
	input wire logic acc_write,
	input wire logic file_write
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence quiet_gap;
		!fetch_strobe [*3] ##1 fetch_strobe;
	endsequence
	sequence nop_slot;
		(nop_cycle && !exec_active) [*4];
	endsequence
	a_strobe_spacing: assert property (fetch_strobe |=> quiet_gap)
		else $error("fetch strobe not every fourth clock");
	a_start_after_strobe: assert property (fetch_strobe |=> cycle_start)
		else $error("cycle start missing");
	a_acc_dest: assert property (acc_write |-> !file_write &&
		!(fields.instr_class == CLASS_REGISTER && fields.result_to_file))
		else $error("accumulator write with file target");
	a_write_slot: assert property ((acc_write || file_write) |-> fetch_strobe && exec_active)
		else $error("write outside executing slot");
	a_bit_field: assert property (fields.instr_class == CLASS_BIT |-> fields.bit_mask == 8'h01 << fields.bit_pos)
		else $error("bit mask wrong");
	a_reg_field: assert property (exec_active && fields.instr_class != CLASS_LITERAL
		|-> fields.reg_addr == exec_word[6:0])
		else $error("register address field wrong");
	a_jump_nop: assert property (fetch_strobe && exec_active && fields.jumps |-> ##2 nop_slot)
		else $error("jump without no-operation cycle");
	a_word_held: assert property ($changed(exec_word) |-> $past(cycle_start))
		else $error("word captured off cycle start");
endmodule

bind cpu_instruction_decode_timing decode_props chk (.sys_clk, .reset, .fetch_strobe,
	.cycle_start, .exec_active, .nop_cycle, .exec_word, .fields, .acc_write, .file_write);

// file: prog_mem_model.sv
// program memory stand-in: word on fetch, scrambled after capture
`timescale 1ns/1ps
module prog_mem_model (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic fetch_strobe,
	input wire logic [13:0] next_word,
	output logic [13:0] instr_word
);
	logic held;
	always @(posedge sys_clk) begin
		held <= fetch_strobe && !reset;
		if (reset)
			instr_word <= 14'h0000;
		else if (fetch_strobe)
			instr_word <= next_word;
		else if (held)
			instr_word <= ~instr_word; // valid only for the capture clock
	end
endmodule

// file: cpu_instruction_decode_timing_tb.sv
// self-checking bench for the decode and timing block
`timescale 1ns/1ps
module cpu_instruction_decode_timing_tb
	import decode_pkg::*;
;
	logic sys_clk = 1'b0;
	logic reset, test_true, pc_changed, fetch_strobe, cycle_start;
	logic exec_active, nop_cycle, acc_write, file_write;
	logic [1:0] phase;
	logic [13:0] instr_word, next_word, exec_word, w;
	logic [31:0] x = 32'h0000005A;
	instr_fields_s fields;
	instr_class_e ec;
	int miscompares, checks, k, cyc;
	bit ex, two, prv, d, cond, wa, wf;
	bit [1:0] cl, c;

	cpu_instruction_decode_timing uut (.sys_clk, .reset, .instr_word, .test_true,
		.pc_changed, .fetch_strobe, .cycle_start, .phase, .exec_active, .nop_cycle,
		.exec_word, .fields, .acc_write, .file_write);
	prog_mem_model mem (.sys_clk, .reset, .fetch_strobe, .next_word, .instr_word);

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok) begin
			miscompares++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		x = xs(x);
		next_word <= x[13:0];
		test_true <= x[20];
		pc_changed <= x[27:25] == 3'h0;
		cyc++;
		if (cyc == 2400) begin
			miscompares++;
			report_and_stop;
		end
	end

	////////////////////////////////////////////////////////////////
	// reference sequencer, one step per clock
	always @(posedge sys_clk) begin
		if (reset) begin
			if (prv)
				chk({fetch_strobe, acc_write, file_write, exec_active, nop_cycle, phase}
					=== 7'h04, "reset");
			prv = 1;
			k = 0;
			ex = 0;
			two = 0;
		end else begin
			prv = 0;
			c = 2'(k);
			if (k >= 4)
				chk({fetch_strobe, cycle_start, phase}
					=== {c == 2'h3, c == 2'h0, c - 2'h1}, "timing");
			chk(exec_active === ex && nop_cycle === !ex, "mode");
			if (ex) begin
				chk(exec_word === w && fields.instr_class === ec, "word");
				chk({fields.conditional, fields.jumps, fields.literal_wide}
					=== {cond, cl == 2'h2, cl == 2'h2}, "flags");
				if (cl < 2'h2)
					chk(fields.reg_addr === w[6:0], "register");
				if (cl == 2'h0)
					chk(fields.result_to_file === d, "target");
				if (cl == 2'h1)
					chk({fields.bit_pos, fields.bit_mask}
						=== {w[9:7], 8'h01 << w[9:7]}, "bit");
				if (cl == 2'h2)
					chk(fields.literal === w[10:0], "long literal");
				if (cl == 2'h3)
					chk(fields.literal[7:0] === w[7:0], "short literal");
			end
			if (ex && c == 2'h2)
				two = cl == 2'h2 || (cond && test_true) || pc_changed;
			chk({acc_write, file_write} === ({2{ex && c == 2'h3}} & {wa, wf}), "write");
			if (c == 2'h0) begin
				// a taken test or branch turns the next slot into a discard
				if (k > 0 && !(ex && two)) begin
					ex = 1;
					w = instr_word;
					cl = w[13:12];
					d = w[7];
					cond = cl == 2'h0 ? (w[11:8] == 4'hB || w[11:8] == 4'hF) : cl == 2'h1 && w[11];
					wa = cl == 2'h3 || (cl == 2'h0 && !d);
					wf = (cl == 2'h0 && d) || (cl == 2'h1 && !w[11]);
					ec = cl == 2'h0 ? CLASS_REGISTER : cl == 2'h1 ? CLASS_BIT : CLASS_LITERAL;
				end else
					ex = 0;
				two = 0;
			end
			k++;
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		reset = 1;
		repeat (2) @(posedge sys_clk);
		reset <= 0;
		repeat (801) @(posedge sys_clk);
		// abort in mid-instruction
		reset <= 1;
		repeat (2) @(posedge sys_clk);
		reset <= 0;
		repeat (800) @(posedge sys_clk);
		report_and_stop;
	end
endmodule
